// >>> hdl/evx_addr_map.sv
// Legacy window address mapper: banked, bypass and control-window routing
`timescale 1ns/100ps
module evx_addr_map
  import evx_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic reset_n, // Synchronous reset, active low
  evx_cfg_if.dst cfg, // Bank configuration
  input wire logic mem_req, // Host memory cycle strobe
  input wire logic [19:0] mem_addr, // Real-mode host address
  input wire logic [1:0] map_sel, // Legacy window size/base select
  output logic [1:0] route_q, // Chosen destination
  output logic [23:0] local_addr_q // Local memory address
);
  // ---------------------------------------------------------------------------
  // Window hit decode
  // ---------------------------------------------------------------------------
  function automatic logic in_window(input logic [1:0] sel, input logic [19:0] a);
    unique case (sel)
      2'b00: in_window = (a[19:17] == 3'b101);
      2'b01: in_window = (a[19:16] == EVX_SEG_A[3:0]);
      2'b10: in_window = (a[19:15] == 5'b10110);
      2'b11: in_window = (a[19:15] == 5'b10111);
    endcase
  endfunction : in_window

  logic [6:0] adder_b;
  logic [6:0] bank_sum;
  logic vga_hit;
  logic ctrl_hit;

  // Second adder input by window size; 32KB windows add nothing so no carry
  always_comb begin
    unique case (map_sel)
      2'b00: adder_b = {5'h00, mem_addr[16:15]};
      2'b01: adder_b = {6'h00, mem_addr[15]};
      default: adder_b = 7'h00;
    endcase
  end
  assign bank_sum = 7'(cfg.bank_off + adder_b);
  assign vga_hit = in_window(map_sel, mem_addr);
  // Whole A0000-BFFFF range is taken from memory; only A-segment answers
  assign ctrl_hit = (mem_addr[19:17] == 3'b101);

  // Registered routing keeps the outputs clean of decode glitches
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      route_q <= EVX_RT_NONE;
      local_addr_q <= 24'h000000;
    end else if (mem_req) begin
      if (cfg.cwin_en) begin
        // Little-endian byte lanes pass straight; no swap path exists here
        route_q <= (ctrl_hit && mem_addr[16] == 1'b0) ? EVX_RT_CTRL : EVX_RT_NONE;
        local_addr_q <= {1'b0, EVX_CTRL_TOP, cfg.cwin_bank, mem_addr[15:0]};
      end else if (vga_hit) begin
        route_q <= cfg.bypass ? EVX_RT_LOCAL : EVX_RT_VGA;
        local_addr_q <= {cfg.hi_off, bank_sum, mem_addr[14:0]};
      end else begin
        route_q <= EVX_RT_NONE;
      end
    end
  end

  a_ctrl_route: assert property (@(posedge clk) disable iff (!reset_n)
    mem_req && cfg.cwin_en && mem_addr[19:16] == 4'hb |=> route_q == EVX_RT_NONE)
    else $error("Control window let B segment through");
  a_bank_add: assert property (@(posedge clk) disable iff (!reset_n)
    mem_req && !cfg.cwin_en && vga_hit && map_sel[1] |=>
    local_addr_q[21:15] == $past(cfg.bank_off))
    else $error("32KB window carried into bank sum");
endmodule : evx_addr_map

// >>> hdl/evx_regs.sv
// Enhanced register group: key lock machine, extended registers, bank mapping
`timescale 1ns/100ps
module evx_regs
  import evx_pkg::*;
(
  input wire logic clk, // System clock, 40 MHz
  input wire logic reset_n, // Synchronous reset, active low
  input wire logic io_wr, // Host I/O write strobe, one cycle
  input wire logic io_rd, // Host I/O read strobe, one cycle
  input wire logic gc_index_sel, // Cycle targets the controller index port
  input wire logic gc_data_sel, // Cycle targets the controller data port
  input wire logic [7:0] io_wdata, // Host write byte
  input wire logic [1:0] map_sel, // Legacy window select from index 06h
  input wire logic mem_req, // Host memory cycle strobe
  input wire logic [19:0] mem_addr, // Real-mode host address
  output logic [7:0] io_rdata_q, // Read data byte
  output logic io_rvalid_q, // Read data valid pulse
  output logic ext_hit_q, // Data read of the previous cycle hit the extended range
  output logic locked_q, // Extended registers locked
  output logic palette_sel_q, // Palette of display 1 selected
  output logic [1:0] route_q, // Memory cycle destination
  output logic [23:0] local_addr_q // Local memory address
);
  // ---------------------------------------------------------------------------
  // Index latch and decode
  // ---------------------------------------------------------------------------
  logic [7:0] index_q;
  logic [7:0] key_last_q;
  logic [7:0] cwin_q;
  logic [7:0] bank_q;
  logic [7:0] pal_q;
  evx_key_e key_q;
  evx_cfg_if cfg ();

  function automatic logic is_ext(input logic [7:0] idx);
    is_ext = (idx[7:4] == EVX_EXT_HI);
  endfunction : is_ext

  logic data_wr;
  logic key_wr;
  logic ext_wr_ok;
  assign data_wr = io_wr && gc_data_sel;
  assign key_wr = data_wr && (index_q == EVX_IDX_KEY);
  assign ext_wr_ok = data_wr && is_ext(index_q) && key_q == EVX_UNLOCKED;

  // Index is held across data writes so both keys may follow one index write
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      index_q <= EVX_RST_BYTE;
    end else if (io_wr && gc_index_sel) begin
      index_q <= io_wdata;
    end
  end

  // ---------------------------------------------------------------------------
  // Key state machine
  // ---------------------------------------------------------------------------
  // Accesses to other ports never reach here, so a preempted sequence survives
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      key_q <= EVX_LOCKED;
    end else if (key_wr) begin
      unique case (key_q)
        EVX_LOCKED: key_q <= (io_wdata == EVX_KEY_FIRST) ? EVX_GOT_FIRST : EVX_LOCKED;
        EVX_GOT_FIRST: begin
          if (io_wdata == EVX_KEY_SECOND) begin
            key_q <= EVX_UNLOCKED;
          end else if (io_wdata == EVX_KEY_FIRST) begin
            key_q <= EVX_GOT_FIRST;
          end else begin
            key_q <= EVX_LOCKED;
          end
        end
        // Once open, the lock byte or any stray byte closes it again
        EVX_UNLOCKED: key_q <= (io_wdata == EVX_KEY_FIRST) ? EVX_GOT_FIRST : EVX_LOCKED;
        default: key_q <= EVX_LOCKED;
      endcase
    end
  end

  // Last byte written at the key index, kept for read-back
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      key_last_q <= EVX_RST_BYTE;
    end else if (key_wr) begin
      key_last_q <= io_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      locked_q <= 1'b1;
    end else begin
      locked_q <= !(key_wr && key_q == EVX_GOT_FIRST && io_wdata == EVX_KEY_SECOND) &&
                  !(key_q == EVX_UNLOCKED && !key_wr);
    end
  end

  // ---------------------------------------------------------------------------
  // Extended registers
  // ---------------------------------------------------------------------------
  // Writes while locked are dropped without a trace
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cwin_q <= EVX_RST_BYTE;
      bank_q <= EVX_RST_BYTE;
      pal_q <= EVX_RST_BYTE;
    end else if (ext_wr_ok) begin
      if (index_q == EVX_IDX_CWIN) cwin_q <= io_wdata;
      if (index_q == EVX_IDX_BANK) bank_q <= io_wdata;
      if (index_q == EVX_IDX_PAL) pal_q <= io_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      palette_sel_q <= 1'b0;
    end else begin
      palette_sel_q <= pal_q[EVX_EN_BIT];
    end
  end

  // ---------------------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------------------
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    unique case (index_q)
      EVX_IDX_KEY: rd_mux = key_last_q;
      EVX_IDX_STAT: rd_mux = {7'h00, key_q != EVX_UNLOCKED};
      EVX_IDX_CWIN: rd_mux = cwin_q;
      EVX_IDX_BANK: rd_mux = bank_q;
      EVX_IDX_PAL: rd_mux = pal_q;
      default: rd_mux = 8'h00;
    endcase
    if (key_q != EVX_UNLOCKED && index_q != EVX_IDX_KEY && index_q != EVX_IDX_STAT) begin
      rd_mux = 8'h00;
    end
  end

  // Extended-range data read answers one cycle after the strobe; other ports and indices leave data at zero
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      io_rdata_q <= 8'h00;
      io_rvalid_q <= 1'b0;
      ext_hit_q <= 1'b0;
    end else begin
      io_rvalid_q <= io_rd && gc_data_sel && is_ext(index_q);
      ext_hit_q <= io_rd && gc_data_sel && is_ext(index_q);
      io_rdata_q <= (io_rd && gc_data_sel && is_ext(index_q)) ? rd_mux : 8'h00;
    end
  end

  // ---------------------------------------------------------------------------
  // Address mapper
  // ---------------------------------------------------------------------------
  assign cfg.cwin_en = cwin_q[EVX_EN_BIT];
  assign cfg.cwin_bank = cwin_q[2:0];
  assign cfg.bypass = bank_q[EVX_EN_BIT];
  assign cfg.bank_off = bank_q[6:0];
  assign cfg.hi_off = pal_q[1:0];

  evx_addr_map u_map (
    .clk(clk),
    .reset_n(reset_n),
    .cfg(cfg),
    .mem_req(mem_req),
    .mem_addr(mem_addr),
    .map_sel(map_sel),
    .route_q(route_q),
    .local_addr_q(local_addr_q)
  );

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  // Keys may be spaced by other cycles, so the first key is taken from the stored byte
  a_unlock_seq: assert property (@(posedge clk) disable iff (!reset_n)
    key_wr && key_last_q == EVX_KEY_FIRST && io_wdata == EVX_KEY_SECOND |=> !locked_q)
    else $error("Key pair did not unlock");
  a_bad_key: assert property (@(posedge clk) disable iff (!reset_n)
    key_wr && io_wdata != EVX_KEY_FIRST && io_wdata != EVX_KEY_SECOND |=> locked_q)
    else $error("Wrong key left registers open");
  a_lock_key: assert property (@(posedge clk) disable iff (!reset_n)
    key_wr && io_wdata == EVX_KEY_LOCK |=> key_q == EVX_LOCKED)
    else $error("Lock byte did not lock");
  a_other_port: assert property (@(posedge clk) disable iff (!reset_n)
    !data_wr |=> key_q == $past(key_q))
    else $error("Key machine moved without a data write");
  // Read-back must get past the lock mask on the read path
  a_key_readback: assert property (@(posedge clk) disable iff (!reset_n)
    io_rd && gc_data_sel && index_q == EVX_IDX_KEY |=> io_rdata_q == $past(key_last_q))
    else $error("Key read-back differs from last write");
  a_status_bit: assert property (@(posedge clk) disable iff (!reset_n)
    io_rd && gc_data_sel && index_q == EVX_IDX_STAT
    |=> io_rdata_q == {7'h00, $past(key_q) != EVX_UNLOCKED})
    else $error("Lock status reads wrong");
  a_locked_wr: assert property (@(posedge clk) disable iff (!reset_n)
    key_q != EVX_UNLOCKED |=> bank_q == $past(bank_q) && cwin_q == $past(cwin_q))
    else $error("Extended write passed while locked");
  a_palette: assert property (@(posedge clk) disable iff (!reset_n)
    ##1 palette_sel_q == $past(pal_q[EVX_EN_BIT]))
    else $error("Palette select does not follow register");
  a_rvalid_ext: assert property (@(posedge clk) disable iff (!reset_n)
    io_rd && gc_data_sel |=> io_rvalid_q == ($past(index_q[7:4]) == EVX_EXT_HI))
    else $error("Read valid disagrees with index range");
  a_rd_idle: assert property (@(posedge clk) disable iff (!reset_n)
    !(io_rd && gc_data_sel) |=> !io_rvalid_q && io_rdata_q == 8'h00)
    else $error("Read data shown without a data read");
  a_locked_rd: assert property (@(posedge clk) disable iff (!reset_n)
    io_rd && gc_data_sel && key_q != EVX_UNLOCKED && index_q != EVX_IDX_KEY &&
    index_q != EVX_IDX_STAT |=> io_rdata_q == 8'h00)
    else $error("Locked read returned register contents");
  a_index_hold: assert property (@(posedge clk) disable iff (!reset_n)
    !(io_wr && gc_index_sel) |=> index_q == $past(index_q))
    else $error("Index changed without an index write");
  a_lock_level: assert property (@(posedge clk) disable iff (!reset_n)
    locked_q == (key_q != EVX_UNLOCKED))
    else $error("Lock output disagrees with key machine");
  a_bank_wr: assert property (@(posedge clk) disable iff (!reset_n)
    data_wr && key_q == EVX_UNLOCKED && index_q == EVX_IDX_BANK |=> bank_q == $past(io_wdata))
    else $error("Unlocked bank write did not land");
endmodule : evx_regs

// >>> include/evx_cfg_if.sv
// Interface carrying the bank configuration from register file to address mapper
`timescale 1ns/100ps
interface evx_cfg_if;
  logic cwin_en;
  logic [2:0] cwin_bank;
  logic bypass;
  logic [6:0] bank_off;
  logic [1:0] hi_off;
  modport src (output cwin_en, cwin_bank, bypass, bank_off, hi_off);
  modport dst (input cwin_en, cwin_bank, bypass, bank_off, hi_off);
endinterface : evx_cfg_if

// >>> include/evx_pkg.sv
// Package of constants for the enhanced VGA unlock and banking register group
// -----------------------------------------------------------------------------
// Functional notes
// - Extended registers stay locked until key 53h then 4Dh written at index 80h.
// - Any wrong byte written at index 80h resets the key machine to locked.
// - Writing 4Ch to the key register locks the extended registers.
// - Only graphics controller data writes advance the key machine; other ports ignored.
// - Keys accepted with index rewritten before each key or written once.
// - Reading the key register returns the last byte written to it.
// - Index 81h is read only; bit 0 is one while locked.
// - Extended registers decode at indices 80h to 8Fh of the controller port.
// - Control window bit 7 maps a 64KB control bank at A0000h to AFFFFh.
// - With control window bit clear the legacy window reaches normal memory.
// - With control window on, the legacy window size select is ignored.
// - Bits 2:0 pick a 64KB bank of 512KB control space; bit 3 ignored.
// - Control window accesses are little-endian only.
// - Bank offset bit 7 selects VGA processing or direct packed-pixel access.
// - Bank offset bits 6:0 added to host bits 21:15, joined with bits 14:0.
// - Adder second input depends on legacy window select; no carry for 32KB.
// - Palette select bit 7 picks display 0 or display 1 palette.
// - Bits 1:0 of index 85h add an offset in 4MB units.
// - Banked window sits at A0000h, B0000h or B8000h by legacy window select and moves in 32KB steps.
// -----------------------------------------------------------------------------
package evx_pkg;
  localparam logic [7:0] EVX_IDX_KEY = 8'h80;
  localparam logic [7:0] EVX_IDX_STAT = 8'h81;
  localparam logic [7:0] EVX_IDX_CWIN = 8'h82;
  localparam logic [7:0] EVX_IDX_BANK = 8'h84;
  localparam logic [7:0] EVX_IDX_PAL = 8'h85;
  localparam logic [3:0] EVX_EXT_HI = 4'h8;
  localparam logic [7:0] EVX_KEY_FIRST = 8'h53;
  localparam logic [7:0] EVX_KEY_SECOND = 8'h4d;
  localparam logic [7:0] EVX_KEY_LOCK = 8'h4c;
  localparam logic [7:0] EVX_RST_BYTE = 8'h00;
  localparam int EVX_EN_BIT = 7;
  localparam int EVX_LOCK_BIT = 0;
  // Control space: 512KB at the top of the first 8MB, so local bits 22:19 are all ones
  localparam logic [3:0] EVX_CTRL_TOP = 4'hf;
  localparam logic [15:0] EVX_SEG_A = 16'h000a;
  localparam logic [15:0] EVX_SEG_B = 16'h000b;
  typedef enum logic [1:0] {EVX_LOCKED, EVX_GOT_FIRST, EVX_UNLOCKED} evx_key_e;
  typedef enum logic [1:0] {EVX_RT_NONE, EVX_RT_VGA, EVX_RT_LOCAL, EVX_RT_CTRL} evx_route_e;
endpackage : evx_pkg

// >>> tb/enhanced_vga_unlock_and_banking_test.sv
// Self-checking bench for the enhanced register group with a reference model
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_compared++; if ((e) !== (g)) begin n_fail++; \
  $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module enhanced_vga_unlock_and_banking_test;
  import evx_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic io_wr, io_rd, gc_index_sel, gc_data_sel, mem_req;
  logic [7:0] io_wdata, io_rdata_q;
  logic [1:0] map_sel, route_q;
  logic [19:0] mem_addr;
  logic io_rvalid_q, ext_hit_q, locked_q, palette_sel_q;
  logic [23:0] local_addr_q;
  int n_fail = 0;
  int n_compared = 0;
  int seed = 30685;
  int ks = 0; // Model key state: 0 locked, 1 first key seen, 2 unlocked
  logic [7:0] m_idx = 8'h00, m_key = 8'h00, m82 = 8'h00, m84 = 8'h00, m85 = 8'h00;
  logic [23:0] m_la = 24'h000000;
  // ---------------------------------------------
  // Clock, instances and closing
  // ---------------------------------------------
  initial begin
    forever #12.5 clk = ~clk;
  end
  evx_regs uut (.clk(clk), .reset_n(reset_n), .io_wr(io_wr), .io_rd(io_rd),
    .gc_index_sel(gc_index_sel), .gc_data_sel(gc_data_sel), .io_wdata(io_wdata),
    .map_sel(map_sel), .mem_req(mem_req), .mem_addr(mem_addr), .io_rdata_q(io_rdata_q),
    .io_rvalid_q(io_rvalid_q), .ext_hit_q(ext_hit_q), .locked_q(locked_q),
    .palette_sel_q(palette_sel_q), .route_q(route_q), .local_addr_q(local_addr_q));
  evx_host host (.clk(clk), .io_rdata_q(io_rdata_q), .io_rvalid_q(io_rvalid_q),
    .ext_hit_q(ext_hit_q),
    .route_q(route_q), .local_addr_q(local_addr_q), .io_wr(io_wr), .io_rd(io_rd),
    .gc_index_sel(gc_index_sel), .gc_data_sel(gc_data_sel), .io_wdata(io_wdata),
    .map_sel(map_sel), .mem_req(mem_req), .mem_addr(mem_addr));
  task automatic end_sim;
    if (n_fail == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim
  // Watchdog cuts a hang short
  initial begin
    repeat (100000) @(posedge clk);
    n_fail++;
    end_sim();
  end
  // Write through the host and step the model
  task automatic wr(input int port, input logic [7:0] d);
    logic [7:0] rdat;
    logic rv;
    host.io_cycle(1'b1, port, d, rdat, rv);
    #1; // Palette flag lands one edge after the register, let it settle
    if (port == 0) begin
      m_idx = d;
    end else if (port == 1 && m_idx == EVX_IDX_KEY) begin
      m_key = d;
      if (d == EVX_KEY_FIRST) ks = 1;
      else if (d == EVX_KEY_SECOND && ks == 1) ks = 2;
      else ks = 0;
    end else if (port == 1 && ks == 2) begin
      if (m_idx == EVX_IDX_CWIN) m82 = d;
      if (m_idx == EVX_IDX_BANK) m84 = d;
      if (m_idx == EVX_IDX_PAL) m85 = d;
    end
    `CHK("locked", ks != 2, locked_q)
    `CHK("palette", m85[7], palette_sel_q)
  endtask : wr
  // Read an index, masking bits whose storage is left open
  task automatic rd(input logic [7:0] idx, input logic [7:0] mask);
    logic [7:0] got, e;
    logic rv;
    wr(0, idx);
    host.io_cycle(1'b0, 1, 8'h00, got, rv);
    case (idx)
      EVX_IDX_KEY: e = m_key;
      EVX_IDX_STAT: e = {7'h00, ks != 2};
      EVX_IDX_CWIN: e = (ks == 2) ? m82 : 8'h00;
      EVX_IDX_BANK: e = (ks == 2) ? m84 : 8'h00;
      EVX_IDX_PAL: e = (ks == 2) ? m85 : 8'h00;
      default: e = 8'h00;
    endcase
    `CHK("read valid", idx[7:4] == EVX_EXT_HI, rv)
    `CHK("ext hit", idx[7:4] == EVX_EXT_HI, host.last_hit)
    if (rv === 1'b1) `CHK("read data", e & mask, got & mask)
  endtask : rd
  // Memory cycle against the mapping model
  task automatic mem(input logic [19:0] a, input logic [1:0] ms);
    logic [1:0] r, er;
    logic [23:0] la;
    logic [6:0] addb;
    logic in_win;
    host.mem_cycle(a, ms, r, la);
    addb = (ms == 2'h0) ? {5'h00, a[16:15]} : (ms == 2'h1) ? {6'h00, a[15]} : 7'h00;
    in_win = (ms == 2'h0) ? a[19:17] == 3'h5 : (ms == 2'h1) ? a[19:16] == 4'ha :
             (ms == 2'h2) ? a[19:15] == 5'h16 : a[19:15] == 5'h17;
    er = 2'h0;
    if (m82[7]) begin
      // Control window takes the address of every cycle; only A segment answers
      er = (a[19:16] == 4'ha) ? 2'h3 : 2'h0;
      m_la = {1'b0, EVX_CTRL_TOP, m82[2:0], a[15:0]};
    end else if (in_win) begin
      er = m84[7] ? 2'h2 : 2'h1;
      m_la = {m85[1:0], m84[6:0] + addb, a[14:0]};
    end
    `CHK("route", er, r)
    `CHK("local address", m_la, la)
  endtask : mem
  // ---------------------------------------------
  // Main sequence
  // ---------------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    `CHK("reset lock", 1'b1, locked_q)
    rd(8'h81, 8'hff);
    rd(8'h80, 8'hff);
    wr(0, EVX_IDX_BANK); // Ignored while locked
    wr(1, 8'h5a);
    rd(8'h84, 8'hff);
    // Keys with the index rewritten and a foreign port access between them
    wr(0, 8'h80);
    wr(1, 8'h53);
    wr(2, 8'h80);
    wr(0, 8'h80);
    wr(1, 8'h4d);
    rd(8'h84, 8'hff);
    rd(8'h80, 8'hff);
    rd(8'h81, 8'hff);
    rd(8'h06, 8'hff);
    // Explicit lock, broken sequence, then index written once
    wr(0, 8'h80);
    wr(1, 8'h4c);
    wr(1, 8'h53);
    wr(1, 8'h12);
    wr(1, 8'h4d);
    rd(8'h81, 8'hff);
    wr(0, 8'h80);
    wr(1, 8'h53);
    wr(1, 8'h4d);
    for (int i = 0; i < 24; i++) begin
      wr(0, 8'h82);
      wr(1, 8'($random(seed)) & 8'h8f);
      wr(0, 8'h84);
      wr(1, 8'($random(seed)));
      wr(0, 8'h85);
      wr(1, 8'($random(seed)) & 8'h83);
      rd(8'h82, 8'h87);
      rd(8'h84, 8'hff);
      rd(8'h85, 8'h83);
      repeat (4) mem({4'(9 + $unsigned($random(seed)) % 4), 16'($random(seed))},
                     2'($random(seed)));
    end
    end_sim();
  end
endmodule : enhanced_vga_unlock_and_banking_test

// >>> tb/evx_host.sv
// Host processor model issuing I/O and memory cycles to the register group
`timescale 1ns/100ps
module evx_host (
  input wire logic clk, // System clock
  input wire logic [7:0] io_rdata_q, // Read byte
  input wire logic io_rvalid_q, // Read valid
  input wire logic ext_hit_q, // Extended range hit
  input wire logic [1:0] route_q, // Memory route
  input wire logic [23:0] local_addr_q, // Local address
  output logic io_wr, // I/O write strobe
  output logic io_rd, // I/O read strobe
  output logic gc_index_sel, // Index port select
  output logic gc_data_sel, // Data port select
  output logic [7:0] io_wdata, // Write byte
  output logic [1:0] map_sel, // Legacy window select
  output logic mem_req, // Memory strobe
  output logic [19:0] mem_addr // Host address
);
  // ---------------------------------------------
  // Bus cycles
  // ---------------------------------------------
  logic last_hit; // Hit flag seen with the last I/O cycle
  // Idle bus at time zero
  initial begin
    last_hit = 1'b0;
    io_wr = 1'b0;
    io_rd = 1'b0;
    gc_index_sel = 1'b0;
    gc_data_sel = 1'b0;
    io_wdata = 8'h00;
    map_sel = 2'h0;
    mem_req = 1'b0;
    mem_addr = 20'h00000;
  end
  // Port 0 index, 1 data, 2 another port pair; a single master, so a key
  // sequence is split by foreign accesses only where the caller issues them
  task automatic io_cycle(input logic wr, input int port, input logic [7:0] d,
                          output logic [7:0] rdata, output logic rvalid);
    @(posedge clk);
    io_wr <= wr;
    io_rd <= ~wr;
    gc_index_sel <= (port == 0);
    gc_data_sel <= (port == 1);
    io_wdata <= d;
    @(posedge clk);
    io_wr <= 1'b0;
    io_rd <= 1'b0;
    gc_index_sel <= 1'b0;
    gc_data_sel <= 1'b0;
    io_wdata <= ~d; // Released data must not look valid
    #1;
    rdata = io_rdata_q;
    rvalid = io_rvalid_q;
    last_hit = ext_hit_q;
    @(posedge clk);
  endtask : io_cycle
  // One memory cycle; the window select is a level and simply holds
  task automatic mem_cycle(input logic [19:0] a, input logic [1:0] ms,
                           output logic [1:0] r, output logic [23:0] la);
    @(posedge clk);
    mem_req <= 1'b1;
    mem_addr <= a;
    map_sel <= ms;
    @(posedge clk);
    mem_req <= 1'b0;
    mem_addr <= ~a;
    #1;
    r = route_q;
    la = local_addr_q;
  endtask : mem_cycle
endmodule : evx_host
